// File: rtl/bre_port.sv
// Function
// - Strap at reset picks mux or direct
// - Mux cycle one: addr 7-2, enables
// - Mux cycle two: addr 15-8
// - Then data bytes on shared lines
// - Mux mode drives active-low chip select
// - Mux mode: two low address pins
// - Bit1 pin shows test enable outside ROM access; options gated
// - EEPROM read serially from input pin
// - Opcodes, address, data shifted out serially
// - Device generates the serial clock
// - EEPROM select asserted during load
// - Direct mode: eight data inputs, bit0 shared
// - Direct address bits 3,4 carry EEPROM
// - Direct select shared by ROM and EEPROM
// - Direct upper address doubles as indicators
// - Mux mode leaves top three pins unused
module bre_port (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // Boot ROM request
  input  wire logic                  rom_req_valid,
  input  wire bre_pkg::bre_rom_req_t rom_req,
  output logic                       rom_req_ready,
  output logic                       rom_rd_valid,
  output logic [bre_pkg::DATA_W-1:0] rom_rd_data,
  // EEPROM request
  input  wire logic                  ee_req_valid,
  input  wire bre_pkg::bre_ee_req_t  ee_req,
  output logic                       ee_req_ready,
  output logic                       ee_done,
  output logic [bre_pkg::EE_W-1:0]   ee_rx_data,
  // Mode, test and indicators
  input  wire logic                  test_mode_req,
  input  wire logic [bre_pkg::LED_W-1:0] led_n,
  output logic                       direct_mode,
  output logic [bre_pkg::TEST_W-1:0] test_opts,
  // Pads
  input  wire bre_pkg::bre_pad_in_t  pad_i,
  output bre_pkg::bre_pad_out_t      pad_o
);
  import bre_pkg::*;

  bre_state_t          state_q;
  logic                mode_q;
  bre_rom_req_t        req_q;
  logic [7:0]          wait_q;
  logic [7:0]          div_q;
  logic                sk_q;
  logic [EE_CNT_W-1:0] bits_q;
  logic [EE_W-1:0]     tx_q;
  logic                test_en_q;
  logic                rom_busy;
  logic                sk_flip;
  logic                serial_prom_in;
  logic                serial_prom_out;
  logic                serial_prom_clk;
  logic                serial_prom_select;
  logic                rom_chip_select_n;
  logic                shared_memory_select;
  logic [ADDR_W-1:0]   ma;

  localparam logic [7:0] WAIT_LAST = 8'(ROM_WAIT_CYC - 1);
  localparam logic [7:0] DIV_LAST  = 8'(SK_HALF_CYC - 1);
  localparam logic [EE_CNT_W-1:0] BITS_ONE = EE_CNT_W'(1);

  assign rom_busy      = (state_q == ST_ADR1) || (state_q == ST_ADR2) || (state_q == ST_DATA);
  assign rom_req_ready = (state_q == ST_IDLE);
  assign ee_req_ready  = (state_q == ST_IDLE) && !rom_req_valid;
  assign direct_mode   = mode_q;
  assign sk_flip       = (state_q == ST_EE) && (div_q == DIV_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture
  // strap sampled
  // Sampled on every edge while reset is held, so the value at release sticks
  // mode held
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_q <= pad_i.p91_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test mode enable and option gating
  // test gating
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      test_en_q <= 1'b0;
      test_opts <= '0;
    end else begin
      test_en_q <= test_mode_req && (mode_q == MODE_MUX);
      test_opts <= (test_en_q && mode_q == MODE_MUX) ? pad_i.p92_94_i : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      req_q   <= '0;
      wait_q  <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          wait_q <= '0;
          if (rom_req_valid) begin
            req_q   <= rom_req;
            state_q <= (mode_q == MODE_MUX) ? ST_ADR1 : ST_DATA;
          end else if (ee_req_valid) begin
            state_q <= ST_EE;
          end
        end
        ST_ADR1: state_q <= ST_ADR2;
        ST_ADR2: state_q <= ST_DATA;
        ST_DATA: begin
          wait_q <= wait_q + 8'h01;
          if (wait_q == WAIT_LAST) begin
            state_q <= ST_IDLE;
          end
        end
        ST_EE: begin
          if (sk_flip && sk_q && bits_q == BITS_ONE) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ROM read capture at the end of the data phase
  // direct data inputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rom_rd_valid <= 1'b0;
      rom_rd_data  <= '0;
    end else begin
      rom_rd_valid <= 1'b0;
      if (state_q == ST_DATA && wait_q == WAIT_LAST && !req_q.write) begin
        rom_rd_valid <= 1'b1;
        rom_rd_data  <= pad_i.bus_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // EEPROM serial engine
  // clock divider
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_q != ST_EE) begin
      div_q <= '0;
      sk_q  <= 1'b0;
    end else if (sk_flip) begin
      div_q <= '0;
      sk_q  <= !sk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Shift out MSB first, sample on the rising clock edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bits_q     <= '0;
      tx_q       <= '0;
      ee_rx_data <= '0;
      ee_done    <= 1'b0;
    end else begin
      ee_done <= 1'b0;
      if (state_q == ST_IDLE && !rom_req_valid && ee_req_valid) begin
        bits_q     <= ee_req.nbits;
        tx_q       <= ee_req.tx;
        ee_rx_data <= '0;
      end else if (sk_flip && !sk_q) begin
        ee_rx_data <= {ee_rx_data[EE_W-2:0], serial_prom_in};
      end else if (sk_flip && sk_q) begin
        tx_q   <= {tx_q[EE_W-2:0], 1'b0};
        bits_q <= bits_q - BITS_ONE;
        ee_done <= (bits_q == BITS_ONE);
      end
    end
  end

  assign serial_prom_select = (state_q == ST_EE);
  assign serial_prom_out    = serial_prom_select ? tx_q[EE_W-1] : 1'b0;
  assign serial_prom_clk    = sk_q;
  assign serial_prom_in     = (mode_q == MODE_DIRECT) ? pad_i.bus_i[0] : pad_i.p87_i;

  //////////////////////////////////////////////////////////////////////////////
  // Pad multiplexing
  // mux chip select
  assign rom_chip_select_n = !rom_busy;
  assign shared_memory_select = (state_q != ST_IDLE);

  // Direct address vector with shared bits folded in
  always_comb begin
    ma = req_q.addr;
    if (serial_prom_select) begin
      ma[DIR_SERIAL_PROM_OUT_BIT] = serial_prom_out;
      ma[DIR_SERIAL_PROM_CLK_BIT] = serial_prom_clk;
    end
    if (!rom_busy) begin
      ma[DIR_LED_MSB:DIR_LED_LSB] = led_n;
    end
  end

  always_comb begin
    pad_o = '0;
    if (mode_q == MODE_MUX) begin
      if (state_q == ST_ADR1) begin
        pad_o.bus_o[C1_ADDR_MSB:C1_ADDR_LSB] = req_q.addr[C1_ADDR_MSB:C1_ADDR_LSB];
        pad_o.bus_o[C1_OE_BIT] = !req_q.write;
        pad_o.bus_o[C1_WE_BIT] = req_q.write;
      end else if (state_q == ST_ADR2) begin
        pad_o.bus_o = req_q.addr[C2_ADDR_MSB:C2_ADDR_LSB];
      end else if (state_q == ST_DATA) begin
        pad_o.bus_o = req_q.wdata;
      end
      pad_o.bus_oe = (state_q == ST_ADR1) || (state_q == ST_ADR2) ||
                     (state_q == ST_DATA && req_q.write);
      pad_o.p83    = rom_chip_select_n;
      pad_o.p85    = req_q.addr[0];
      pad_o.p86    = rom_busy ? req_q.addr[1] : test_en_q;
      pad_o.p88    = serial_prom_out;
      pad_o.p89    = serial_prom_clk;
      pad_o.p90    = serial_prom_select;
      pad_o.p95_98 = led_n;
      pad_o.p99_101_oe = 1'b0;
    end else begin
      pad_o.p83        = shared_memory_select;
      pad_o.p85        = ma[0];
      pad_o.p86        = ma[1];
      pad_o.p87_o      = ma[2];
      pad_o.p87_oe     = 1'b1;
      pad_o.p88        = ma[DIR_SERIAL_PROM_OUT_BIT];
      pad_o.p89        = ma[DIR_SERIAL_PROM_CLK_BIT];
      pad_o.p90        = ma[5];
      pad_o.p91_o      = ma[6];
      pad_o.p91_oe     = !sys_rst;
      pad_o.p92_94_o   = ma[DIR_TEST_MSB:DIR_TEST_LSB];
      pad_o.p92_94_oe  = 1'b1;
      pad_o.p95_98     = ma[DIR_LED_MSB:DIR_LED_LSB];
      pad_o.p99_101_o  = ma[DIR_TOP_MSB:DIR_TOP_LSB];
      pad_o.p99_101_oe = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_strap_capture: assert property (
    $fell(sys_rst) |-> mode_q == $past(pad_i.p91_i))
    else $error("mode not taken from strap");
  chk_mode_stable: assert property (
    1'b1 |=> $stable(mode_q))
    else $error("mode changed outside reset");
  chk_mux_first_cycle: assert property (
    state_q == ST_ADR1 && mode_q == MODE_MUX |-> pad_o.bus_oe &&
      pad_o.bus_o[7:2] == req_q.addr[7:2] && pad_o.bus_o[1] == req_q.write)
    else $error("first address cycle wrong");
  chk_mux_second_cycle: assert property (
    state_q == ST_ADR1 |=> state_q == ST_ADR2 && pad_o.bus_o == req_q.addr[15:8])
    else $error("second address cycle wrong");
  chk_mux_data_phase: assert property (
    state_q == ST_ADR2 |=> (state_q == ST_DATA)[*4] ##1 state_q == ST_IDLE)
    else $error("data phase length wrong");
  chk_mux_select: assert property (
    mode_q == MODE_MUX |-> pad_o.p83 == !rom_busy)
    else $error("mux chip select wrong");
  chk_low_addr: assert property (
    mode_q == MODE_MUX && rom_busy |-> pad_o.p85 == req_q.addr[0] &&
      pad_o.p86 == req_q.addr[1])
    else $error("low address pins wrong");
  chk_test_gate: assert property (
    mode_q == MODE_DIRECT |=> test_opts == '0)
    else $error("test options leak in direct mode");
  chk_sk_period: assert property (
    $changed(sk_q) && state_q == ST_EE |-> $past(div_q) == DIV_LAST)
    else $error("serial clock half period wrong");
  chk_ee_select: assert property (
    $rose(sk_q) |-> serial_prom_select)
    else $error("serial clock without select");
  chk_direct_shared: assert property (
    mode_q == MODE_DIRECT && serial_prom_select |-> pad_o.p88 == tx_q[EE_W-1] &&
      pad_o.p89 == sk_q)
    else $error("direct serial pins wrong");
  chk_direct_select: assert property (
    mode_q == MODE_DIRECT |-> pad_o.p83 == (state_q != ST_IDLE))
    else $error("direct select wrong");
  chk_led_idle: assert property (
    mode_q == MODE_DIRECT && !rom_busy |-> pad_o.p95_98 == led_n)
    else $error("indicators not shown when idle");
  chk_top_unused: assert property (
    mode_q == MODE_MUX |-> !pad_o.p99_101_oe)
    else $error("top pins driven in mux mode");
  chk_rx_sample: assert property (
    $rose(sk_q) |-> ee_rx_data[0] == $past(serial_prom_in))
    else $error("serial input not sampled on clock rise");
  chk_tx_steady: assert property (
    serial_prom_select && sk_q |-> $stable(serial_prom_out))
    else $error("serial output moved while clock high");
  chk_done_deselect: assert property (
    ee_done |-> !serial_prom_select && $past(serial_prom_select))
    else $error("done pulse not at end of select");
  chk_direct_data_in: assert property (
    mode_q == MODE_DIRECT && state_q == ST_DATA && wait_q == WAIT_LAST && !req_q.write |=>
      rom_rd_valid && rom_rd_data == $past(pad_i.bus_i))
    else $error("direct read data not captured");
  chk_test_off: assert property (
    mode_q == MODE_MUX && !test_en_q |=> test_opts == '0)
    else $error("test options leak without test mode");

  cov_mux_read: cover property (mode_q == MODE_MUX && rom_rd_valid);
  cov_direct_read: cover property (mode_q == MODE_DIRECT && rom_rd_valid);
  cov_ee_done: cover property (ee_done);
  cov_mux_write: cover property (mode_q == MODE_MUX && state_q == ST_DATA && req_q.write);

endmodule // bre_port

// File: rtl/bre_pkg.sv
package bre_pkg;

  // Pin arrangement selected by the strap
  localparam logic MODE_MUX    = 1'b0;
  localparam logic MODE_DIRECT = 1'b1;

  // Widths
  localparam int ADDR_W   = 17;
  localparam int DATA_W   = 8;
  localparam int EE_W     = 32;
  localparam int EE_CNT_W = 6;
  localparam int LED_W    = 4;
  localparam int TEST_W   = 3;

  // First and second address cycle layout on the shared lines
  localparam int C1_OE_BIT   = 0;
  localparam int C1_WE_BIT   = 1;
  localparam int C1_ADDR_LSB = 2;
  localparam int C1_ADDR_MSB = 7;
  localparam int C2_ADDR_LSB = 8;
  localparam int C2_ADDR_MSB = 15;

  // Direct mode address bits with a second use, plus the unshared top bits
  localparam int DIR_SERIAL_PROM_OUT_BIT = 3;
  localparam int DIR_SERIAL_PROM_CLK_BIT = 4;
  localparam int DIR_LED_LSB  = 10;
  localparam int DIR_LED_MSB  = 13;
  localparam int DIR_TEST_LSB = 7;
  localparam int DIR_TEST_MSB = 9;
  localparam int DIR_TOP_LSB  = 14;
  localparam int DIR_TOP_MSB  = 16;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SK_HALF_NS    = 500;
  localparam int ROM_ACCESS_NS = 200;
  localparam int SK_HALF_CYC   = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROM_WAIT_CYC  = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bre_rom_req_t;

  typedef struct packed {
    logic [EE_CNT_W-1:0] nbits;
    logic [EE_W-1:0]     tx;
  } bre_ee_req_t;

  // Pads 75..101 as seen from the core
  typedef struct packed {
    logic [DATA_W-1:0] bus_i;
    logic              p87_i;
    logic              p91_i;
    logic [TEST_W-1:0] p92_94_i;
  } bre_pad_in_t;

  typedef struct packed {
    logic [DATA_W-1:0] bus_o;
    logic              bus_oe;
    logic              p83;
    logic              p85;
    logic              p86;
    logic              p87_o;
    logic              p87_oe;
    logic              p88;
    logic              p89;
    logic              p90;
    logic              p91_o;
    logic              p91_oe;
    logic [TEST_W-1:0] p92_94_o;
    logic              p92_94_oe;
    logic [LED_W-1:0]  p95_98;
    logic [2:0]        p99_101_o;
    logic              p99_101_oe;
  } bre_pad_out_t;

  typedef enum {ST_IDLE, ST_ADR1, ST_ADR2, ST_DATA, ST_EE} bre_state_t;

endpackage

// File: verification/bre_far_model.sv
module bre_far_model
  import bre_pkg::*;
#(
  parameter logic [31:0] EE_PAT = 32'hA5C3_0F96
) (
  // Clock, board straps
  input  wire logic                  core_clk,
  input  wire logic                  direct,
  input  wire logic                  ee_path,
  // Pads seen by ROM and EEPROM
  input  wire bre_pkg::bre_pad_out_t po,
  output logic [7:0]                 bus_i,
  output logic                       din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  ph_q;
  logic [7:0]  lo_q;
  logic [7:0]  hi_q;
  logic [7:0]  last_q;
  logic [4:0]  idx_q;
  logic        sck_q;
  logic        dl_q;
  logic        sel;
  logic        rom_on;
  logic [16:0] dir_a;
  ////////////////////////////////////////
  // latch follows cycle order
  always_ff @(posedge core_clk) begin
    if (direct || po.p83) begin
      ph_q <= 2'h0;
    end else if (ph_q != 2'h3) begin
      ph_q <= ph_q + 2'h1;
    end
    if (ph_q == 2'h0) lo_q <= {po.bus_o[7:2], po.p86, po.p85};
    if (ph_q == 2'h1) hi_q <= po.bus_o;
    last_q <= bus_i;
  end
  // Address as seen on direct pins
  assign dir_a = {po.p99_101_o, po.p95_98, po.p92_94_o, po.p91_o, po.p90,
                  po.p89, po.p88, po.p87_o, po.p86, po.p85};
  assign rom_on = direct ? (po.p83 && !ee_path) : (ph_q[1] && !po.p83 && !po.bus_oe);
  assign sel = direct ? (po.p83 && ee_path) : po.p90;
  // Released lines toggle instead of holding
  assign din = sel ? EE_PAT[idx_q] : ~dl_q;
  always_comb begin
    bus_i = ~last_q;
    if (rom_on) bus_i = direct ? (dir_a[7:0] ^ dir_a[15:8]) : (lo_q ^ hi_q);
    if (direct && sel) bus_i[0] = din;
  end
  // EEPROM moves to next bit on falling clock
  always_ff @(posedge core_clk) begin
    sck_q <= po.p89;
    dl_q <= din;
    if (!sel) idx_q <= 5'h1F;
    else if (sck_q && !po.p89) idx_q <= idx_q - 5'h1;
  end
endmodule // bre_far_model

// File: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bre_pkg::*;
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
  end
  localparam logic [31:0] PAT = 32'h96C3_5A0F;
  logic         core_clk, sys_rst, rom_req_valid, ee_req_valid, test_mode_req;
  logic         strap, ee_path, rom_req_ready, rom_rd_valid, ee_req_ready;
  logic         ee_done, direct_mode, m_din;
  logic [7:0]   rom_rd_data, m_bus;
  logic [31:0]  ee_rx_data;
  logic [3:0]   led_n;
  logic [2:0]   test_opts, topt;
  bre_rom_req_t rom_req;
  bre_ee_req_t  ee_req;
  bre_pad_in_t  pad_i;
  bre_pad_out_t pad_o;
  int           n_fail, cmp_count, cyc;
  assign pad_i = {m_bus, m_din, strap, topt};
  bre_port uut (.core_clk(core_clk), .sys_rst(sys_rst), .rom_req_valid(rom_req_valid),
    .rom_req(rom_req), .rom_req_ready(rom_req_ready), .rom_rd_valid(rom_rd_valid),
    .rom_rd_data(rom_rd_data), .ee_req_valid(ee_req_valid), .ee_req(ee_req),
    .ee_req_ready(ee_req_ready), .ee_done(ee_done), .ee_rx_data(ee_rx_data),
    .test_mode_req(test_mode_req), .led_n(led_n), .direct_mode(direct_mode),
    .test_opts(test_opts), .pad_i(pad_i), .pad_o(pad_o));
  bre_far_model #(.EE_PAT(PAT)) far (.core_clk(core_clk), .direct(direct_mode),
    .ee_path(ee_path), .po(pad_o), .bus_i(m_bus), .din(m_din));
  ////////////////////////////////////////
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    @(negedge core_clk);
    strap = s;
    sys_rst = 1'b1;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    `CHK("mode", s, direct_mode)
  endtask
  // Issue a ROM request, return in first cycle after it is taken
  task automatic rom_go(input logic w, input logic [16:0] a, input logic [7:0] d);
    @(negedge core_clk);
    rom_req = '{w, a, d};
    rom_req_valid = 1'b1;
    `CHK("ready", 1'b1, rom_req_ready)
    @(negedge core_clk);
    rom_req_valid = 1'b0;
  endtask
  task automatic fin_rom(input int n, input int want, input logic rd, input logic [7:0] ed);
    while (rom_req_ready !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("rom_len", want, n)
    if (rd) `CHK("rd_valid", 1'b1, rom_rd_valid)
    if (rd) `CHK("rd_data", ed, rom_rd_data)
  endtask
  task automatic t_mux_rom(input logic w, input logic [16:0] a, input logic [7:0] d);
    rom_go(w, a, d);
    `CHK("adr1", {a[7:2], w, !w}, pad_o.bus_o)
    `CHK("cs_n", 1'b0, pad_o.p83)
    `CHK("a_low", a[1:0], {pad_o.p86, pad_o.p85})
    `CHK("top_oe", 1'b0, pad_o.p99_101_oe)
    @(negedge core_clk);
    `CHK("adr2", a[15:8], pad_o.bus_o)
    @(negedge core_clk);
    `CHK("dat_oe", w, pad_o.bus_oe)
    if (w) `CHK("wdata", d, pad_o.bus_o)
    fin_rom(3, 7, !w, a[7:0] ^ a[15:8]);
    `CHK("cs_off", 1'b1, pad_o.p83)
  endtask
  task automatic t_dir_rom(input logic [16:0] a);
    rom_go(1'b0, a, 8'h00);
    `CHK("ma3_4", a[4:3], {pad_o.p89, pad_o.p88})
    `CHK("ma6", a[6], pad_o.p91_o)
    `CHK("ma10", a[13:10], pad_o.p95_98)
    `CHK("ma14", a[16:14], pad_o.p99_101_o)
    `CHK("rom_sel", 1'b1, pad_o.p83)
    fin_rom(1, 5, 1'b1, a[7:0] ^ a[15:8]);
  endtask
  // Eight-bit serial transfer, bits captured on rising serial clock
  task automatic t_ee(input logic [7:0] tx);
    logic [7:0] got;
    logic       pc;
    int         k;
    int         n;
    got = 8'h00;
    pc = 1'b0;
    k = 0;
    n = 0;
    ee_path = 1'b1;
    @(negedge core_clk);
    ee_req = '{6'h08, {tx, 24'h00_0000}};
    ee_req_valid = 1'b1;
    `CHK("ee_ready", 1'b1, ee_req_ready)
    @(negedge core_clk);
    ee_req_valid = 1'b0;
    while (ee_done !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
      if (ee_done !== 1'b1) `CHK("ee_sel", 1'b1, direct_mode ? pad_o.p83 : pad_o.p90)
      if (pad_o.p89 && !pc) got = {got[6:0], pad_o.p88};
      if (pad_o.p89 && !pc) k++;
      pc = pad_o.p89;
    end
    `CHK("ee_clks", 8, k)
    `CHK("ee_done", 1'b1, ee_done)
    `CHK("ee_len", 16 * SK_HALF_CYC, n)
    `CHK("ee_tx", tx, got)
    `CHK("ee_rx", PAT[31:24], ee_rx_data[7:0])
    ee_path = 1'b0;
  endtask
  task automatic t_test(input logic [2:0] want);
    @(negedge core_clk);
    test_mode_req = 1'b1;
    topt = 3'h5;
    repeat (2) @(negedge core_clk);
    `CHK("test_opts", want, test_opts)
    `CHK("test_pin", want != 3'h0, pad_o.p86)
    test_mode_req = 1'b0;
    topt = 3'h0;
    repeat (2) @(negedge core_clk);
    `CHK("opts_off", 3'h0, test_opts)
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {sys_rst, rom_req_valid, ee_req_valid, test_mode_req, strap, ee_path} = 6'h20;
    rom_req = '0;
    ee_req = '0;
    topt = 3'h0;
    led_n = 4'hA;
    do_reset(1'b0);
    t_mux_rom(1'b0, 17'h1_3A6D, 8'h00);
    t_mux_rom(1'b1, 17'h0_C5B2, 8'h5A);
    t_mux_rom(1'b0, 17'h0_FFFF, 8'h00);
    t_ee(8'hC5);
    t_test(3'h5);
    do_reset(1'b1);
    strap = 1'b0;
    t_dir_rom(17'h1_5A4C);
    t_ee(8'h3B);
    t_test(3'h0);
    `CHK("led", led_n, pad_o.p95_98)
    `CHK("mode_kept", 1'b1, direct_mode)
    finish_test();
  end
endmodule // tb
